//--- hdl/dual_timer_unit.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module dual_timer_unit
  import dual_timer_pkg::*;
(
  input  wire logic        CLK,        // module clock, 250 MHz
  input  wire logic        SYS_RST,    // synchronous reset, active high
  input  wire logic [7:0]  ADDR,       // register byte address
  input  wire logic [31:0] WDATA,      // write data
  input  wire logic        WR,         // write strobe
  input  wire logic        RD,         // read strobe
  output logic      [31:0] RDATA,      // read data, cycle after RD
  input  wire logic [7:0]  IN_LINES,   // external input lines, asynchronous
  input  wire logic [3:0]  CASC_TRG,   // cascade trigger signals
  input  wire logic [3:0]  CASC_OUT,   // cascade output overflow selections
  input  wire logic [3:0]  CASC_SR,    // cascade request overflow selections
  output logic      [7:0]  OUT_PINS,   // output latch bits to the port
  output logic      [7:0]  SR_REQ,     // request node pulses
  output logic      [1:0]  OUV_HALF    // overflow pulses of lower/upper half
);

  typedef struct packed {
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [11:0] prev;
    logic [1:0]  run;
    logic [1:0]  dir;
    logic [31:0] cnt;
    logic [31:0] rc0;
    logic [31:0] rc1;
    logic [31:0] con;
    logic [31:0] rccon;
    logic [31:0] ais;
    logic [31:0] bis;
    logic [31:0] es;
    logic [31:0] output_source_select;
    logic [31:0] service_request_select;
    logic [31:0] rdata;
    logic [7:0]  outl;
    logic [7:0]  sr;
    logic [1:0]  ouv;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [3:0] line_idx(input logic [3:0] sel);
    line_idx = sel[3] ? {2'b10, sel[1:0]} : {1'b0, sel[2:0]};
  endfunction

  // edge-qualified event of the selected line
  function automatic logic line_ev(input logic [11:0] cur, input logic [11:0] prv,
                                   input logic [3:0] sel, input logic [1:0] edg);
    logic [3:0] i;
    i = line_idx(sel);
    line_ev = (edg[0] & cur[i] & ~prv[i]) | (edg[1] & ~cur[i] & prv[i]); // [RL4]
  endfunction

  function automatic logic line_lvl(input logic [11:0] v, input logic [3:0] sel);
    line_lvl = v[line_idx(sel)];
  endfunction

  always_comb begin
    logic [11:0]      cur;
    logic [1:0][6:0]  ev;
    logic [31:0]      selr;
    logic             split;
    logic             w32;
    logic [15:0]      ctl;
    logic [15:0]      rcm;
    logic [31:0]      v;
    logic [31:0]      nv;
    logic [31:0]      r0;
    logic [31:0]      r1;
    logic             qa;
    logic             qb;
    logic             qap;
    logic             qbp;
    logic             qstep;
    logic             cevt;
    logic             step;
    logic             up;
    logic             wrap;
    logic             ouv;
    logic             cap0;
    logic             cap1;
    logic             rl0;
    logic             rl1;
    logic             clr;
    logic [1:0]       setr;
    logic [1:0]       clrr;
    logic [1:0]       ouv_now;
    logic [5:0]       osrc;
    logic [15:0]      evs;
    logic [2:0]       output_source_select_f;
    logic [2:0]       m;
    cur     = {CASC_TRG, s_q.sync2};
    ev      = '0;
    selr    = '0;
    split   = s_q.con[FLD_SPLIT];
    w32     = 1'b0;
    ctl     = '0;
    rcm     = '0;
    v       = '0;
    nv      = '0;
    r0      = '0;
    r1      = '0;
    qa      = 1'b0;
    qb      = 1'b0;
    qap     = 1'b0;
    qbp     = 1'b0;
    qstep   = 1'b0;
    cevt    = 1'b0;
    step    = 1'b0;
    up      = 1'b0;
    wrap    = 1'b0;
    ouv     = 1'b0;
    cap0    = 1'b0;
    cap1    = 1'b0;
    rl0     = 1'b0;
    rl1     = 1'b0;
    clr     = 1'b0;
    setr    = '0;
    clrr    = '0;
    ouv_now = '0;
    osrc    = '0;
    evs     = '0;
    output_source_select_f  = '0;
    m       = '0;
    s_d     = s_q;

    // only the second stage reads the first
    s_d.sync1 = IN_LINES;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = cur;

    // run requests from software, write-one pulses
    setr[0] = WR && ADDR == OFS_RUN && WDATA[FLD_SETR];                      // [RL8]
    clrr[0] = WR && ADDR == OFS_RUN && WDATA[FLD_CLRR];                      // [RL8]
    setr[1] = WR && ADDR == OFS_RUN && WDATA[RUN_STRIDE + FLD_SETR];         // [RL8]
    clrr[1] = WR && ADDR == OFS_RUN && WDATA[RUN_STRIDE + FLD_CLRR];         // [RL8]

    // edge selection stage, per half and function
    for (int h = 0; h < 2; h++) begin
      selr = (h == 0) ? s_q.ais : s_q.bis;
      for (int f = 0; f < N_FUNC; f++) begin
        ev[h][f] = line_ev(cur, s_q.prev, selr[f*4 +: 4],
                           s_q.es[h*HALF_W + f*2 +: 2]);                      // [RL3] [RL7] [RL15]
      end
    end

    for (int h = 0; h < 2; h++) begin
      if (h == 0 || split) begin
        // joined mode lets the lower half's controls run all 32 bits
        w32  = ~split;                                                       // [RL2] [RL5]
        ctl  = s_q.con[h*HALF_W +: HALF_W];                                  // [RL5]
        rcm  = s_q.rccon[h*HALF_W +: HALF_W];                                // [RL13]
        selr = (h == 0) ? s_q.ais : s_q.bis;

        // quadrature decode on the levels of count and up/down lines
        qa    = line_lvl(cur, selr[F_CNT*4 +: 4]);
        qb    = line_lvl(cur, selr[F_UD*4 +: 4]);
        qap   = line_lvl(s_q.prev, selr[F_CNT*4 +: 4]);
        qbp   = line_lvl(s_q.prev, selr[F_UD*4 +: 4]);
        qstep = (qa ^ qap) | (qb ^ qbp);                                     // [RL16]

        if (csrc_t'(ctl[FLD_CSRC +: 2]) == CS_QUAD) begin
          if (qstep) begin
            s_d.dir[h] = ~(qa ^ qbp);                                        // [RL16]
          end
        end else begin
          case (dsrc_t'(ctl[FLD_CDIR +: 2]))
            DS_UP:   s_d.dir[h] = 1'b0;                                      // [RL11]
            DS_DOWN: s_d.dir[h] = 1'b1;                                      // [RL11]
            DS_LINE: s_d.dir[h] = s_q.dir[h] ^ ev[h][F_UD];                  // [RL11]
            default: s_d.dir[h] = s_q.dir[h];
          endcase
        end
        up = ~s_d.dir[h];

        case (csrc_t'(ctl[FLD_CSRC +: 2]))
          CS_CLOCK: cevt = 1'b1;                                             // [RL6]
          CS_EXT:   cevt = ev[h][F_CNT];                                     // [RL6] [RL7]
          CS_QUAD:  cevt = qstep;                                            // [RL6] [RL16]
          default:  cevt = 1'b0;
        endcase
        step = s_q.run[h] & cevt;

        v  = w32 ? s_q.cnt : {16'h0000, s_q.cnt[h*HALF_W +: HALF_W]};
        r0 = w32 ? s_q.rc0 : {16'h0000, s_q.rc0[h*HALF_W +: HALF_W]};
        r1 = w32 ? s_q.rc1 : {16'h0000, s_q.rc1[h*HALF_W +: HALF_W]};
        // upper half rides on the lower half's carry/borrow in 32-bit mode
        if (w32) begin
          wrap = up ? (v == 32'hFFFF_FFFF) : (v == 32'h0000_0000);           // [RL23]
        end else begin
          wrap = up ? (v[15:0] == 16'hFFFF) : (v[15:0] == 16'h0000);         // [RL1]
        end
        ouv = step & wrap;
        nv  = step ? (up ? v + 32'h1 : v - 32'h1) : v;
        if (!w32) begin
          nv[31:16] = 16'h0000;
        end

        m = rcm[0 +: 3];
        cap0 = (rc_mode_t'(m) == RC_CAPTURE) & ev[h][F_RC0];                 // [RL14]
        case (rc_mode_t'(m))
          RC_REL_OUV:    rl0 = ouv;                                          // [RL14]
          RC_REL_EXT:    rl0 = ev[h][F_RC0];
          RC_REL_OVF:    rl0 = ouv & up;
          RC_REL_UNF:    rl0 = ouv & ~up;
          RC_REL_EXT_UP: rl0 = ev[h][F_RC0] & ~s_q.dir[h];
          RC_REL_EXT_DN: rl0 = ev[h][F_RC0] & s_q.dir[h];
          default:       rl0 = 1'b0;
        endcase
        m = rcm[FLD_MRC1 +: 3];
        cap1 = (rc_mode_t'(m) == RC_CAPTURE) & ev[h][F_RC1];                 // [RL13] [RL14]
        case (rc_mode_t'(m))
          RC_REL_OUV:    rl1 = ouv;                                          // [RL14]
          RC_REL_EXT:    rl1 = ev[h][F_RC1];
          RC_REL_OVF:    rl1 = ouv & up;
          RC_REL_UNF:    rl1 = ouv & ~up;
          RC_REL_EXT_UP: rl1 = ev[h][F_RC1] & ~s_q.dir[h];
          RC_REL_EXT_DN: rl1 = ev[h][F_RC1] & s_q.dir[h];
          default:       rl1 = 1'b0;
        endcase

        case (csel_t'(ctl[FLD_CCLR +: 2]))
          CL_EXT:  clr = ev[h][F_CLR];                                       // [RL12]
          CL_CP0:  clr = cap0;                                               // [RL12]
          CL_CP1:  clr = cap1;                                               // [RL12]
          default: clr = 1'b0;
        endcase

        // capture takes the value seen at the event, before clearing
        if (cap0) begin
          r0 = v;
        end
        if (cap1) begin
          r1 = v;
        end
        if (clr) begin
          nv = 32'h0000_0000;
        end
        if (rl0) begin
          nv = w32 ? s_q.rc0 : {16'h0000, s_q.rc0[h*HALF_W +: HALF_W]};
        end
        if (rl1) begin
          nv = w32 ? s_q.rc1 : {16'h0000, s_q.rc1[h*HALF_W +: HALF_W]};
        end

        if (w32) begin
          s_d.cnt = nv;
          s_d.rc0 = r0;
          s_d.rc1 = r1;
        end else begin
          s_d.cnt[h*HALF_W +: HALF_W] = nv[15:0];
          s_d.rc0[h*HALF_W +: HALF_W] = r0[15:0];
          s_d.rc1[h*HALF_W +: HALF_W] = r1[15:0];
        end
        ouv_now[h] = ouv;                                                    // [RL23]

        // start beats stop so a start in the stopping cycle is kept
        if (setr[h] | ev[h][F_STR]) begin
          s_d.run[h] = 1'b1;                                                 // [RL8]
        end else if (clrr[h] | ev[h][F_STP] | (ctl[FLD_ONESHOT] & ouv)) begin
          s_d.run[h] = 1'b0;                                                 // [RL8] [RL9]
        end
      end
    end
    // in joined mode the upper run bit still follows its own requests
    if (!split) begin
      if (setr[1] | ev[1][F_STR]) begin
        s_d.run[1] = 1'b1;
      end else if (clrr[1] | ev[1][F_STP]) begin
        s_d.run[1] = 1'b0;
      end
    end
    s_d.ouv = ouv_now;

    // register writes; a software write beats the counter and slot updates
    if (WR) begin
      case (ADDR)
        OFS_CON:   s_d.con   = WDATA & MASK_CON;                             // [RL2]
        OFS_RCCON: s_d.rccon = WDATA & MASK_RCCON;
        OFS_AIS:   s_d.ais   = WDATA & MASK_IS;
        OFS_BIS:   s_d.bis   = WDATA & MASK_IS;
        OFS_ES:    s_d.es    = WDATA & MASK_ES;
        OFS_OUTPUT_SOURCE_SELECT:  s_d.output_source_select  = WDATA & MASK_OUTPUT_SOURCE_SELECT;
        OFS_OUT:   s_d.outl  = WDATA[7:0];                                   // [RL17]
        OFS_COUNT: s_d.cnt   = WDATA;
        OFS_RC0:   s_d.rc0   = WDATA;
        OFS_RC1:   s_d.rc1   = WDATA;
        OFS_SERVICE_REQUEST_SELECT: s_d.service_request_select = WDATA;
        default:   s_d.service_request_select = s_d.service_request_select;
      endcase
    end

    // output bits toggle on their chosen overflow, on top of any write
    osrc = {ouv_now, CASC_OUT};
    for (int i = 0; i < 8; i++) begin
      output_source_select_f = s_q.output_source_select[i*4 +: 3];
      if (output_source_select_f < OUTPUT_SOURCE_SELECT_NSRC && osrc[output_source_select_f]) begin
        s_d.outl[i] = ~s_d.outl[i];                                          // [RL18]
      end
    end

    // request events straight from the edge selection stage
    evs = {CASC_SR, ouv_now[1], ev[1][F_RC1], ev[1][F_RC0], ev[1][F_STP],
           ev[1][F_STR], ouv_now[0], ev[0][F_RC1], ev[0][F_RC0],
           ev[0][F_CLR], ev[0][F_UD], ev[0][F_STP], ev[0][F_STR]};           // [RL20] [RL21]
    for (int i = 0; i < 8; i++) begin
      s_d.sr[i] = evs[s_q.service_request_select[i*4 +: 4]];                                  // [RL19] [RL22]
    end

    s_d.rdata = '0;
    if (RD) begin
      case (ADDR)
        OFS_CON:   s_d.rdata = {s_q.con[31:24], s_q.dir[1], s_q.con[22:8],
                                s_q.dir[0], s_q.con[6:0]};
        OFS_RCCON: s_d.rdata = s_q.rccon;
        OFS_AIS:   s_d.rdata = s_q.ais;
        OFS_BIS:   s_d.rdata = s_q.bis;
        OFS_ES:    s_d.rdata = s_q.es;
        OFS_OUTPUT_SOURCE_SELECT:  s_d.rdata = s_q.output_source_select;
        OFS_OUT:   s_d.rdata = {24'h000000, s_q.outl};                       // [RL17]
        OFS_COUNT: s_d.rdata = s_q.cnt;
        OFS_RC0:   s_d.rdata = s_q.rc0;
        OFS_RC1:   s_d.rdata = s_q.rc1;
        OFS_RUN:   s_d.rdata = {27'h0, s_q.run[1], 3'h0, s_q.run[0]};         // [RL10]
        OFS_SERVICE_REQUEST_SELECT: s_d.rdata = s_q.service_request_select;
        default:   s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA    = s_q.rdata;
  assign OUT_PINS = s_q.outl;
  assign SR_REQ   = s_q.sr;
  assign OUV_HALF = s_q.ouv;

endmodule // dual_timer_unit

//--- inc/dual_timer_pkg.sv
// Overview of operation
// RL1 - two 16-bit halves, each with a counter and two reload/capture slots
// RL2 - split bit chooses two 16-bit timers or one 32-bit timer
// RL3 - any of eight lines or cascade triggers can drive any function
// RL4 - each trigger acts on rising, falling or both edges
// RL5 - joined halves obey lower half controls; split halves obey their own
// RL6 - clock source picks module clock, external count or quadrature counting
// RL7 - count trigger chosen from a line or cascade trigger with its own edge
// RL8 - run bit set/cleared by request bits and by start/stop line edges
// RL9 - one-shot mode stops the half on its own overflow or underflow
// RL10 - run bits read back the running or stopped state
// RL11 - direction fixed up, fixed down, or toggled by an edge on a line
// RL12 - clear source: external edge, capture-0 event or capture-1 event
// RL13 - both slots of each half have their own mode, source and edge
// RL14 - slot modes: off, capture, reload on wrap, external, per direction
// RL15 - slot trigger taken from a line or cascade trigger with its edge
// RL16 - quadrature: edges of two encoder phases count, phase sets direction
// RL17 - eight output bits drive the port pins and software writes them
// RL18 - each output picks one of six overflow sources that toggles it
// RL19 - eight request nodes, each free to select any of sixteen events
// RL20 - events: start, stop, slots, overflow, lower up/down and clear, cascade
// RL21 - request events are taken straight from the edge selection stage
// RL22 - one event may fire several request nodes at once
// RL23 - joined mode: upper half takes carry/borrow, overflow shown as lower's
package dual_timer_pkg;

  localparam logic [7:0] OFS_CASC_IRS  = 8'h10;
  localparam logic [7:0] OFS_CASC_OTS  = 8'h14;
  localparam logic [7:0] OFS_CON       = 8'h18;
  localparam logic [7:0] OFS_RCCON     = 8'h1C;
  localparam logic [7:0] OFS_AIS       = 8'h20;
  localparam logic [7:0] OFS_BIS       = 8'h24;
  localparam logic [7:0] OFS_ES        = 8'h28;
  localparam logic [7:0] OFS_OUTPUT_SOURCE_SELECT      = 8'h2C;
  localparam logic [7:0] OFS_OUT       = 8'h30;
  localparam logic [7:0] OFS_C0_CNT    = 8'h34;
  localparam logic [7:0] OFS_C0_CNT24  = 8'h38;
  localparam logic [7:0] OFS_C0_REL    = 8'h3C;
  localparam logic [7:0] OFS_C0_REL24  = 8'h40;
  localparam logic [7:0] OFS_C1_CNT    = 8'h44;
  localparam logic [7:0] OFS_C1_CNT24  = 8'h48;
  localparam logic [7:0] OFS_C1_REL    = 8'h4C;
  localparam logic [7:0] OFS_C1_REL24  = 8'h50;
  localparam logic [7:0] OFS_COUNT     = 8'h54;
  localparam logic [7:0] OFS_RC0       = 8'h58;
  localparam logic [7:0] OFS_RC1       = 8'h5C;
  localparam logic [7:0] OFS_RUN       = 8'h60;
  localparam logic [7:0] OFS_SERVICE_REQUEST_SELECT     = 8'hDC;

  localparam int HALF_W      = 16;
  localparam int FLD_CSRC    = 0;
  localparam int FLD_CDIR    = 2;
  localparam int FLD_CCLR    = 4;
  localparam int FLD_ONESHOT = 6;
  localparam int FLD_DIR     = 7;
  localparam int FLD_SPLIT   = 31;
  localparam int FLD_MRC1    = 4;
  localparam int RUN_STRIDE  = 4;
  localparam int FLD_RUN     = 0;
  localparam int FLD_SETR    = 1;
  localparam int FLD_CLRR    = 2;

  // nibble index of each function in the input select registers
  localparam int F_CNT = 0;
  localparam int F_STR = 1;
  localparam int F_STP = 2;
  localparam int F_UD  = 3;
  localparam int F_CLR = 4;
  localparam int F_RC0 = 5;
  localparam int F_RC1 = 6;
  localparam int N_FUNC = 7;

  localparam logic [31:0] MASK_CON   = 32'h807F_007F;
  localparam logic [31:0] MASK_RCCON = 32'h0077_0077;
  localparam logic [31:0] MASK_IS    = 32'h0FFF_FFFF;
  localparam logic [31:0] MASK_ES    = 32'h3FFF_3FFF;
  localparam logic [31:0] MASK_OUTPUT_SOURCE_SELECT  = 32'h7777_7777;
  localparam logic [31:0] MASK_OUT   = 32'h0000_00FF;
  localparam logic [31:0] RST_VAL    = 32'h0000_0000;
  localparam logic [2:0]  OUTPUT_SOURCE_SELECT_NSRC  = 3'h6;

  typedef enum logic [1:0] {CS_CLOCK, CS_EXT, CS_QUAD, CS_NONE} csrc_t;
  typedef enum logic [1:0] {DS_UP, DS_DOWN, DS_LINE, DS_HOLD} dsrc_t;
  typedef enum logic [1:0] {CL_NONE, CL_EXT, CL_CP0, CL_CP1} csel_t;
  typedef enum logic [2:0] {
    RC_OFF, RC_CAPTURE, RC_REL_OUV, RC_REL_EXT,
    RC_REL_OVF, RC_REL_UNF, RC_REL_EXT_UP, RC_REL_EXT_DN
  } rc_mode_t;

endpackage

//--- verification/dual_timer_checker.sv
`timescale 1ns/1ps
module dual_timer_checker
  import dual_timer_pkg::*;
(
  input wire logic        CLK,      // module clock
  input wire logic        SYS_RST,  // synchronous reset
  input wire logic [7:0]  ADDR,     // register address
  input wire logic [31:0] WDATA,    // write data
  input wire logic        WR,       // write strobe
  input wire logic        RD,       // read strobe
  input wire logic [31:0] RDATA,    // read data
  input wire logic [7:0]  IN_LINES, // input lines
  input wire logic [3:0]  CASC_TRG, // cascade triggers
  input wire logic [3:0]  CASC_OUT, // cascade output overflows
  input wire logic [3:0]  CASC_SR,  // cascade request overflows
  input wire logic [7:0]  OUT_PINS, // output latch
  input wire logic [7:0]  SR_REQ,   // request nodes
  input wire logic [1:0]  OUV_HALF  // half overflows
);
  logic        split_q;
  logic [31:0] service_request_select_q;
  // shadow of the two control fields the properties depend on
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      split_q <= 1'b0;
      service_request_select_q <= 32'h0000_0000;
    end else if (WR) begin
      if (ADDR == OFS_CON) split_q <= WDATA[FLD_SPLIT];
      if (ADDR == OFS_SERVICE_REQUEST_SELECT) service_request_select_q <= WDATA;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_rd_idle; !$past(RD) |-> RDATA == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_no_reg;
    RD && (ADDR == OFS_CASC_IRS || ADDR == OFS_CASC_OTS || ADDR == 8'h00) |=> RDATA == 32'h0;
  endproperty
  a_no_reg: assert property (p_no_reg) else $error("foreign location read nonzero");
  property p_con_mask; RD && ADDR == OFS_CON |=> (RDATA & ~MASK_CON & ~32'h0080_0080) == 0;
  endproperty
  a_con_mask: assert property (p_con_mask) else $error("control reserved bits set");
  property p_run_set;
    (WR && ADDR == OFS_RUN && WDATA[2:0] == 3'h2) ##1 (RD && ADDR == OFS_RUN) |=> RDATA[0];
  endproperty
  a_run_set: assert property (p_run_set) else $error("run bit not set");
  property p_run_clr;
    (WR && ADDR == OFS_RUN && WDATA[2:0] == 3'h4) ##1 (RD && ADDR == OFS_RUN) |=> !RDATA[0];
  endproperty
  a_run_clr: assert property (p_run_clr) else $error("run bit not cleared");
  property p_out_wr;
    WR && ADDR == OFS_OUT && OUV_HALF == 2'h0 && CASC_OUT == 4'h0
      |=> OUT_PINS == $past(WDATA[7:0]) || OUV_HALF != 2'h0;
  endproperty
  a_out_wr: assert property (p_out_wr) else $error("output latch write lost");
  property p_out_cause;
    $changed(OUT_PINS) |-> $past(WR && ADDR == OFS_OUT) || OUV_HALF != 2'h0
      || $past(CASC_OUT) != 4'h0 || $past(CASC_OUT, 2) != 4'h0;
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output changed without cause");
  property p_joined_ovf; !split_q && !$past(split_q) |-> !OUV_HALF[1]; endproperty
  a_joined_ovf: assert property (p_joined_ovf) else $error("upper overflow when joined");
  property p_sr_multi;
    CASC_SR[0] && service_request_select_q[7:0] == 8'hCC |-> ##[1:2] SR_REQ[1:0] == 2'h3;
  endproperty
  a_sr_multi: assert property (p_sr_multi) else $error("shared event missed a node");
endmodule // dual_timer_checker

//--- verification/input_pins_model.sv
`timescale 1ns/1ps
module input_pins_model (
  input wire logic       CLK,   // module clock
  output logic     [7:0] LINES  // pin levels
);
  logic [1:0] ph_q = 2'h0;
  initial LINES = 8'h00;
  // held long enough to pass the two-flop synchroniser
  task automatic pulse(input int k);
    @(posedge CLK);
    LINES[k] <= 1'b1;
    repeat (3) @(posedge CLK);
    LINES[k] <= 1'b0;
    repeat (5) @(posedge CLK);
  endtask
  task automatic step(input logic up);
    @(posedge CLK);
    ph_q = up ? ph_q + 2'h1 : ph_q - 2'h1;
    LINES[1:0] <= {ph_q[1], ph_q[1] ^ ph_q[0]}; // phase a leads b when going up
    repeat (5) @(posedge CLK);
  endtask
endmodule // input_pins_model

//--- verification/dual_timer_quadrature_unit_bench.sv
`timescale 1ns/1ps
module dual_timer_quadrature_unit_bench
  import dual_timer_pkg::*;
;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [3:0]  CASC_SR = 4'h0;
  logic [3:0]  CASC_TRG = 4'h0;
  logic [3:0]  CASC_OUT = 4'h0;
  logic [31:0] RDATA;
  logic [7:0]  IN_LINES;
  logic [7:0]  OUT_PINS;
  logic [7:0]  SR_REQ;
  logic [1:0]  OUV_HALF;
  logic [31:0] d;
  int          fails = 0;
  int          checks_done = 0;
  always #2 CLK = ~CLK;
  input_pins_model pins (.CLK(CLK), .LINES(IN_LINES));
  dual_timer_unit DUT (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .IN_LINES(IN_LINES), .CASC_TRG(CASC_TRG), .CASC_OUT(CASC_OUT),
    .CASC_SR(CASC_SR), .OUT_PINS(OUT_PINS), .SR_REQ(SR_REQ), .OUV_HALF(OUV_HALF));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  // bounded wait for bits of {SR_REQ, OUV_HALF}; a miss ends the run
  task automatic wait_for(input string n, input int lim, input logic [9:0] m);
    for (int i = 0; i < lim && ({SR_REQ, OUV_HALF} & m) !== m; i++)
      @(posedge CLK) #1;
    chk(n, {22'h0, m}, {22'h0, {SR_REQ, OUV_HALF} & m});
    if (({SR_REQ, OUV_HALF} & m) !== m) complete_run();
  endtask
  task automatic t_regs();
    logic [7:0] offs [12] = '{OFS_CON, OFS_RCCON, OFS_AIS, OFS_BIS, OFS_ES, OFS_OUTPUT_SOURCE_SELECT,
                              OFS_OUT, OFS_COUNT, OFS_RC0, OFS_RC1, OFS_RUN, OFS_SERVICE_REQUEST_SELECT};
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("reset value", RST_VAL, d);
    end
    wr(OFS_CASC_IRS, 32'hFFFF_FFFF);
    rd(OFS_CASC_IRS);
    chk("cascade location", 32'h0, d);
    wr(OFS_CON, 32'hFFFF_FFFF);
    rd(OFS_CON);
    chk("control mask", MASK_CON, d);
    wr(OFS_CON, RST_VAL);
    wr(OFS_OUT, 32'h0000_00A5);
    chk("output pins", 32'hA5, {24'h0, OUT_PINS});
    rd(OFS_OUT);
    chk("output latch", 32'hA5, d);
    $display("register test done");
  endtask
  task automatic t_run();
    wr(OFS_RUN, 32'h2);
    rd(OFS_RUN);
    chk("lower run set", 32'h1, d & 32'h11);
    wr(OFS_RUN, 32'h24);
    rd(OFS_RUN);
    chk("upper run only", 32'h10, d & 32'h11);
    wr(OFS_RUN, 32'h40);
    $display("run test done");
  endtask
  task automatic t_oneshot();
    wr(OFS_CON, 32'h0000_0040);
    wr(OFS_OUTPUT_SOURCE_SELECT, 32'h0000_0004);
    wr(OFS_OUT, 32'h0);
    wr(OFS_COUNT, 32'hFFFF_FFF0);
    wr(OFS_RUN, 32'h2);
    wait_for("joined overflow", 40, 10'h001);
    chk("joined upper pulse", 32'h0, {31'h0, OUV_HALF[1]});
    chk("overflow toggles output", 32'h1, {24'h0, OUT_PINS});
    rd(OFS_RUN);
    chk("one-shot stop", 32'h0, d & 32'h1);
    wr(OFS_CON, 32'h8000_0004);
    wr(OFS_COUNT, 32'h0000_0003);
    wr(OFS_RUN, 32'h2);
    wait_for("split underflow", 20, 10'h001);
    chk("split upper quiet", 32'h0, {31'h0, OUV_HALF[1]});
    rd(OFS_CON);
    chk("down status", 32'h80, d & 32'h80);
    rd(OFS_COUNT);
    chk("upper half held", 32'h0, d & 32'hFFFF_0000);
    wr(OFS_RUN, 32'h4);
    $display("overflow test done");
  endtask
  task automatic t_quad();
    wr(OFS_CON, 32'h0000_0002);
    wr(OFS_AIS, 32'h0000_1000);
    wr(OFS_ES, 32'h0000_00C3);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_RUN, 32'h2);
    repeat (8) pins.step(1'b1);
    repeat (3) pins.step(1'b0);
    rd(OFS_COUNT);
    chk("quadrature count", 32'h5, d);
    wr(OFS_RUN, 32'h4);
    $display("quadrature test done");
  endtask
  task automatic t_ext();
    logic [31:0] n = 32'h0;
    wr(OFS_CON, 32'h0000_0001);
    wr(OFS_AIS, 32'h0003_0002);
    wr(OFS_SERVICE_REQUEST_SELECT, 32'h0000_0033);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_RUN, 32'h2);
    for (int e = 1; e < 4; e++) begin
      wr(OFS_ES, 32'h0000_0100 | e);
      repeat (2) pins.pulse(2);
      n = n + ((e == 3) ? 4 : 2);
      rd(OFS_COUNT);
      chk("external count edges", n, d);
    end
    fork
      pins.pulse(3);
      wait_for("clear line requests", 12, 10'h00C);
    join
    rd(OFS_COUNT);
    chk("request without clear", n, d);
    wr(OFS_CON, 32'h0000_0011);
    pins.pulse(3);
    rd(OFS_COUNT);
    chk("external clear", 32'h0, d);
    wr(OFS_SERVICE_REQUEST_SELECT, 32'h0000_00CC);
    fork
      begin
        CASC_SR <= 4'h1;
        @(posedge CLK);
        CASC_SR <= 4'h0;
      end
      wait_for("cascade request pair", 6, 10'h00C);
    join
    wr(OFS_RUN, 32'h4);
    wr(OFS_CON, 32'h0);
    $display("external input test done");
  endtask
  task automatic t_slot();
    wr(OFS_COUNT, 32'h1234_5678);
    wr(OFS_AIS, 32'h0040_0000);
    wr(OFS_ES, 32'h0000_0400);
    wr(OFS_RCCON, 32'h1);
    pins.pulse(4);
    rd(OFS_RC0);
    chk("capture on line", 32'h1234_5678, d);
    wr(OFS_RC0, 32'h0000_0055);
    wr(OFS_RCCON, 32'h3);
    pins.pulse(4);
    rd(OFS_COUNT);
    chk("reload on line", 32'h0000_0055, d);
    $display("slot test done");
  endtask
  // outputs 1..7 still follow cascade output 0 from the source select value written in t_oneshot
  task automatic t_casc();
    wr(OFS_OUT, 32'h0);
    CASC_OUT <= 4'h1;
    @(posedge CLK);
    CASC_OUT <= 4'h0;
    #1;
    chk("cascade output toggle", 32'hFE, {24'h0, OUT_PINS});
    wr(OFS_CON, 32'h0000_0001);
    wr(OFS_AIS, 32'h0000_0008);
    wr(OFS_ES, 32'h0000_0001);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_RUN, 32'h2);
    CASC_TRG <= 4'h1;
    @(posedge CLK);
    CASC_TRG <= 4'h0;
    #1;
    rd(OFS_COUNT);
    chk("cascade count trigger", 32'h1, d);
    wr(OFS_RUN, 32'h4);
    $display("cascade test done");
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    #1;
    t_regs();
    t_run();
    t_oneshot();
    t_quad();
    t_ext();
    t_slot();
    t_casc();
    complete_run();
  end
  initial begin
    repeat (50000) @(posedge CLK);
    fails++;
    complete_run();
  end
endmodule // dual_timer_quadrature_unit_bench
bind dual_timer_unit dual_timer_checker chk_i (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IN_LINES(IN_LINES), .CASC_TRG(CASC_TRG),
  .CASC_OUT(CASC_OUT), .CASC_SR(CASC_SR), .OUT_PINS(OUT_PINS), .SR_REQ(SR_REQ),
  .OUV_HALF(OUV_HALF));
